// file: logic/event_latch_pkg.sv
// Package: register map, reset values and widths for the channel event latch
package event_latch_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int NUM_CH = 64;
  localparam int CODE_W = 6;

  // ****************************************
  // Register offsets (byte addresses)
  // ****************************************
  localparam logic [ADDR_W-1:0] OFS_EVENT_PENDING_LOW = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_EVENT_PENDING_HIGH = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_EVENT_CLEAR_LOW = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_EVENT_CLEAR_HIGH = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_MANUAL_SET_LOW = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_MANUAL_SET_HIGH = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_CHAIN_EVENT_LOW = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_CHAIN_EVENT_HIGH = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_MISSED_EVENT_LOW = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_MISSED_EVENT_HIGH = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_MISSED_CLEAR_LOW = 8'h28;
  localparam logic [ADDR_W-1:0] OFS_MISSED_CLEAR_HIGH = 8'h2C;
  localparam logic [ADDR_W-1:0] OFS_CHANNEL_ENABLE_LOW = 8'h30;
  localparam logic [ADDR_W-1:0] OFS_CHANNEL_ENABLE_HIGH = 8'h34;
  localparam logic [ADDR_W-1:0] OFS_ENABLE_SET_LOW = 8'h38;
  localparam logic [ADDR_W-1:0] OFS_ENABLE_SET_HIGH = 8'h3C;
  localparam logic [ADDR_W-1:0] OFS_ENABLE_CLEAR_LOW = 8'h40;
  localparam logic [ADDR_W-1:0] OFS_ENABLE_CLEAR_HIGH = 8'h44;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [NUM_CH-1:0] RST_CHANNELS = 64'h0000_0000_0000_0000;
  localparam logic [DATA_W-1:0] RST_WORD = 32'h0000_0000;

endpackage

// file: logic/dma_channel_event_latch.sv
// Per-channel event capture for external, manual and chained DMA events
//
// Added by the designer: the register addresses and strobed register access.
`timescale 1ns/1ps

module dma_channel_event_latch
  import event_latch_pkg::*;
#(
  parameter int CHANNELS = NUM_CH
) (
  input wire logic sys_clk,
  input wire logic rst,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [DATA_W-1:0] reg_rdata,
  // External event pulses, one per channel
  input wire logic [CHANNELS-1:0] ext_event,
  // Completion code returned by a transfer controller
  input wire logic tc_done_valid,
  input wire logic [CODE_W-1:0] tc_completion_code,
  input wire logic tc_intermediate_chain_enable,
  input wire logic tc_final_chain_enable,
  // Completion code produced by the early completion path
  input wire logic early_done_valid,
  input wire logic [CODE_W-1:0] early_completion_code,
  input wire logic early_intermediate_chain_enable,
  input wire logic early_final_chain_enable,
  // Submission done by the prioritiser, one-hot per serviced channel
  input wire logic [CHANNELS-1:0] submit_done,
  // Candidates offered to prioritisation
  output logic [CHANNELS-1:0] candidate,
  output logic [CHANNELS-1:0] missed_event
);

  // ****************************************
  // State
  // ****************************************
  logic [CHANNELS-1:0] pending_reg;
  logic [CHANNELS-1:0] manual_reg;
  logic [CHANNELS-1:0] chain_reg;
  logic [CHANNELS-1:0] missed_reg;
  logic [CHANNELS-1:0] enable_reg;

  // ****************************************
  // Register write decode into 64-bit masks
  // ****************************************
  logic [CHANNELS-1:0] pend_clr_mask;
  logic [CHANNELS-1:0] man_set_mask;
  logic [CHANNELS-1:0] miss_clr_mask;
  logic [CHANNELS-1:0] en_set_mask;
  logic [CHANNELS-1:0] en_clr_mask;

  function automatic logic [CHANNELS-1:0] word_mask(
    input logic hit_low,
    input logic hit_high,
    input logic [DATA_W-1:0] data
  );
    logic [2*DATA_W-1:0] wide;
    wide = {(hit_high ? data : RST_WORD), (hit_low ? data : RST_WORD)};
    return wide[CHANNELS-1:0];
  endfunction

  // ****************************************
  // Write strobes, one per writable register
  // ****************************************
  logic wr_pend_clr_low;
  logic wr_pend_clr_high;
  logic wr_man_set_low;
  logic wr_man_set_high;
  logic wr_miss_clr_low;
  logic wr_miss_clr_high;
  logic wr_en_set_low;
  logic wr_en_set_high;
  logic wr_en_clr_low;
  logic wr_en_clr_high;

  always_comb begin
    wr_pend_clr_low = reg_write && (reg_addr == OFS_EVENT_CLEAR_LOW);
    wr_pend_clr_high = reg_write && (reg_addr == OFS_EVENT_CLEAR_HIGH);
    wr_man_set_low = reg_write && (reg_addr == OFS_MANUAL_SET_LOW);
    wr_man_set_high = reg_write && (reg_addr == OFS_MANUAL_SET_HIGH);
    wr_miss_clr_low = reg_write && (reg_addr == OFS_MISSED_CLEAR_LOW);
    wr_miss_clr_high = reg_write && (reg_addr == OFS_MISSED_CLEAR_HIGH);
    wr_en_set_low = reg_write && (reg_addr == OFS_ENABLE_SET_LOW);
    wr_en_set_high = reg_write && (reg_addr == OFS_ENABLE_SET_HIGH);
    wr_en_clr_low = reg_write && (reg_addr == OFS_ENABLE_CLEAR_LOW);
    wr_en_clr_high = reg_write && (reg_addr == OFS_ENABLE_CLEAR_HIGH);
  end

  // Low word covers channels 0-31, high word channels 32-63
  always_comb begin
    pend_clr_mask = word_mask(wr_pend_clr_low, wr_pend_clr_high, reg_wdata);
    man_set_mask = word_mask(wr_man_set_low, wr_man_set_high, reg_wdata);
    miss_clr_mask = word_mask(wr_miss_clr_low, wr_miss_clr_high, reg_wdata);
    en_set_mask = word_mask(wr_en_set_low, wr_en_set_high, reg_wdata);
    en_clr_mask = word_mask(wr_en_clr_low, wr_en_clr_high, reg_wdata);
  end

  // ****************************************
  // Chaining completion decode
  // ****************************************
  logic [CHANNELS-1:0] tc_chain_hit;
  logic [CHANNELS-1:0] early_chain_hit;
  logic [CHANNELS-1:0] chain_hit;
  logic [CHANNELS-1:0] chain_dup;

  // Returned completion asking for intermediate or final chaining
  always_comb begin
    tc_chain_hit = '0;
    if (tc_done_valid && (tc_intermediate_chain_enable || tc_final_chain_enable)) begin
      tc_chain_hit[tc_completion_code] = 1'b1;
    end
  end

  // Completion produced internally by the early completion path
  always_comb begin
    early_chain_hit = '0;
    if (early_done_valid &&
        (early_intermediate_chain_enable || early_final_chain_enable)) begin
      early_chain_hit[early_completion_code] = 1'b1;
    end
  end

  // Two codes for one channel in a cycle: the second is lost
  assign chain_hit = tc_chain_hit | early_chain_hit;
  assign chain_dup = tc_chain_hit & early_chain_hit;

  // ****************************************
  // Submission routing, per channel
  // ****************************************
  logic [CHANNELS-1:0] ext_ready;
  logic [CHANNELS-1:0] pend_hw_clr;
  logic [CHANNELS-1:0] man_hw_clr;
  logic [CHANNELS-1:0] chain_hw_clr;

  // A submission retires one source only: the external latch when it is
  // evaluable, else the manual bit, else the chained bit
  for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_route
    assign ext_ready[ch] = pending_reg[ch] & enable_reg[ch];
    // Only an enabled channel's submission clears its external latch
    assign pend_hw_clr[ch] = submit_done[ch] & ext_ready[ch];
    // Event clear writes never reach the manual bits
    assign man_hw_clr[ch] = submit_done[ch] & ~ext_ready[ch] & manual_reg[ch];
    assign chain_hw_clr[ch] = submit_done[ch] & ~ext_ready[ch] & ~manual_reg[ch] & chain_reg[ch];
  end

  // ****************************************
  // Lost events, per channel
  // ****************************************
  logic [CHANNELS-1:0] miss_set;

  for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_loss
    logic ext_lost;
    logic man_lost;
    logic chain_lost;

    // A disabled channel never reports a lost external event
    assign ext_lost = ext_event[ch] & ext_ready[ch];
    assign man_lost = man_set_mask[ch] & manual_reg[ch];
    assign chain_lost = (chain_hit[ch] & chain_reg[ch]) | chain_dup[ch];
    assign miss_set[ch] = ext_lost | man_lost | chain_lost;
  end

  // ****************************************
  // Next values: a set always wins over a clear in the same cycle
  // ****************************************
  logic [CHANNELS-1:0] enable_next;
  logic [CHANNELS-1:0] pending_next;
  logic [CHANNELS-1:0] manual_next;
  logic [CHANNELS-1:0] chain_next;
  logic [CHANNELS-1:0] missed_next;
  logic [CHANNELS-1:0] candidate_next;

  always_comb begin
    enable_next = (enable_reg & ~en_clr_mask) | en_set_mask;
    pending_next = (pending_reg & ~pend_hw_clr & ~pend_clr_mask) | ext_event;
    manual_next = (manual_reg & ~man_hw_clr) | man_set_mask;
    chain_next = (chain_reg & ~chain_hw_clr) | chain_hit;
    // A new miss in the clearing cycle is kept
    missed_next = (missed_reg & ~miss_clr_mask) | miss_set;
    // Candidates show the state after the edge
    candidate_next = (pending_next & enable_next)
                   | manual_next
                   | chain_next;
  end

  // ****************************************
  // Channel enables, set and clear by write
  // ****************************************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      enable_reg <= RST_CHANNELS;
    end else begin
      enable_reg <= enable_next;
    end
  end

  // ****************************************
  // External event pending latch
  // ****************************************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pending_reg <= RST_CHANNELS;
    end else begin
      pending_reg <= pending_next;
    end
  end

  // ****************************************
  // Manual event set bits
  // ****************************************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      manual_reg <= RST_CHANNELS;
    end else begin
      manual_reg <= manual_next;
    end
  end

  // ****************************************
  // Chained event bits
  // ****************************************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      chain_reg <= RST_CHANNELS;
    end else begin
      chain_reg <= chain_next;
    end
  end

  // ****************************************
  // Missed events
  // ****************************************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      missed_reg <= RST_CHANNELS;
    end else begin
      missed_reg <= missed_next;
    end
  end

  // ****************************************
  // Missed event output, a registered copy
  // ****************************************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      missed_event <= RST_CHANNELS;
    end else begin
      missed_event <= missed_next;
    end
  end

  // ****************************************
  // Candidates for prioritisation
  // ****************************************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      candidate <= RST_CHANNELS;
    end else begin
      candidate <= candidate_next;
    end
  end

  // ****************************************
  // Register read port
  // ****************************************
  logic [2*DATA_W-1:0] pend_w;
  logic [2*DATA_W-1:0] man_w;
  logic [2*DATA_W-1:0] chain_w;
  logic [2*DATA_W-1:0] miss_w;
  logic [2*DATA_W-1:0] en_w;
  logic [DATA_W-1:0] rdata_next;

  always_comb begin
    pend_w = '0;
    man_w = '0;
    chain_w = '0;
    miss_w = '0;
    en_w = '0;
    pend_w[CHANNELS-1:0] = pending_reg;
    man_w[CHANNELS-1:0] = manual_reg;
    chain_w[CHANNELS-1:0] = chain_reg;
    miss_w[CHANNELS-1:0] = missed_reg;
    en_w[CHANNELS-1:0] = enable_reg;
    rdata_next = RST_WORD;
    if (reg_read) begin
      unique case (reg_addr)
        OFS_EVENT_PENDING_LOW: rdata_next = pend_w[DATA_W-1:0];
        OFS_EVENT_PENDING_HIGH: rdata_next = pend_w[2*DATA_W-1:DATA_W];
        OFS_MANUAL_SET_LOW: rdata_next = man_w[DATA_W-1:0];
        OFS_MANUAL_SET_HIGH: rdata_next = man_w[2*DATA_W-1:DATA_W];
        OFS_CHAIN_EVENT_LOW: rdata_next = chain_w[DATA_W-1:0];
        OFS_CHAIN_EVENT_HIGH: rdata_next = chain_w[2*DATA_W-1:DATA_W];
        OFS_MISSED_EVENT_LOW: rdata_next = miss_w[DATA_W-1:0];
        OFS_MISSED_EVENT_HIGH: rdata_next = miss_w[2*DATA_W-1:DATA_W];
        OFS_CHANNEL_ENABLE_LOW: rdata_next = en_w[DATA_W-1:0];
        OFS_CHANNEL_ENABLE_HIGH: rdata_next = en_w[2*DATA_W-1:DATA_W];
        // Write-only and unmapped addresses read as zero
        default: rdata_next = RST_WORD;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= RST_WORD;
    end else begin
      reg_rdata <= rdata_next;
    end
  end

endmodule

// file: verif/event_latch_monitor.sv
// Checker for the channel event latch ports
`timescale 1ns/1ps
module event_latch_monitor
  import event_latch_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic [NUM_CH-1:0] ext_event,
  input wire logic tc_done_valid,
  input wire logic [CODE_W-1:0] tc_completion_code,
  input wire logic tc_intermediate_chain_enable,
  input wire logic tc_final_chain_enable,
  input wire logic early_done_valid,
  input wire logic [CODE_W-1:0] early_completion_code,
  input wire logic early_intermediate_chain_enable,
  input wire logic early_final_chain_enable,
  input wire logic [NUM_CH-1:0] submit_done,
  input wire logic [NUM_CH-1:0] candidate,
  input wire logic [NUM_CH-1:0] missed_event
);
  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic man_wr;
  logic quiet;
  assign man_wr = reg_write && reg_addr == OFS_MANUAL_SET_LOW;
  assign quiet = !reg_write && ext_event == '0 && !tc_done_valid && !early_done_valid;
  AST_MANUAL_SET: assert property (man_wr |=>
    (candidate[31:0] & $past(reg_wdata)) == $past(reg_wdata)) else $error("manual set lost");
  AST_SET_WINS: assert property (man_wr && reg_wdata[0] && submit_done[0] |=>
    candidate[0]) else $error("clear beat set");
  AST_TC_CHAIN: assert property (tc_done_valid && (tc_intermediate_chain_enable ||
    tc_final_chain_enable) |=> candidate[$past(tc_completion_code)]) else $error("no chain");
  AST_EARLY_CHAIN: assert property (early_done_valid && (early_intermediate_chain_enable ||
    early_final_chain_enable) |=> candidate[$past(early_completion_code)])
    else $error("no early chain");
  AST_NO_RISE: assert property (quiet |=> (candidate & ~$past(candidate)) == '0)
    else $error("candidate rose alone");
  AST_HOLD: assert property (submit_done == '0 && !reg_write |=>
    (~candidate & $past(candidate)) == '0) else $error("candidate dropped");
  AST_WO_READ: assert property (reg_read && (reg_addr == OFS_EVENT_CLEAR_LOW ||
    reg_addr == OFS_EVENT_CLEAR_HIGH) |=> reg_rdata == '0) else $error("clear readable");
  AST_MISSED_KEEP: assert property (!reg_write |=>
    (~missed_event & $past(missed_event)) == '0) else $error("missed lost");
  COV_MANUAL: cover property (man_wr ##1 candidate != '0);
  COV_CHAIN: cover property (tc_done_valid && tc_final_chain_enable);
  COV_SUBMIT: cover property (submit_done != '0 ##1 candidate == '0);
endmodule

// file: verif/tc_model.sv
// Transfer controller model returning completion codes after a delay
`timescale 1ns/1ps
module tc_model
  import event_latch_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic req,
  input wire logic [CODE_W+1:0] req_info,
  input wire logic [3:0] req_delay,
  output logic tc_done_valid,
  output logic [CODE_W-1:0] tc_completion_code,
  output logic tc_intermediate_chain_enable,
  output logic tc_final_chain_enable
);
  logic busy;
  logic [3:0] wait_reg;
  logic [CODE_W+1:0] info_reg;
  // Idle code lines show the inverse of the last completion
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      busy <= 1'b0;
      wait_reg <= 4'h0;
      info_reg <= '0;
      tc_done_valid <= 1'b0;
      {tc_intermediate_chain_enable, tc_final_chain_enable, tc_completion_code} <= '0;
    end else if (req) begin
      busy <= 1'b1;
      wait_reg <= req_delay;
      info_reg <= req_info;
    end else if (busy && wait_reg != 4'h0) begin
      wait_reg <= wait_reg - 4'h1;
    end else if (busy) begin
      busy <= 1'b0;
      tc_done_valid <= 1'b1;
      {tc_intermediate_chain_enable, tc_final_chain_enable, tc_completion_code} <= info_reg;
    end else begin
      tc_done_valid <= 1'b0;
      {tc_intermediate_chain_enable, tc_final_chain_enable, tc_completion_code} <= ~info_reg;
    end
  end
endmodule

// file: verif/testbench.sv
// Self-checking bench for the channel event latch
`timescale 1ns/1ps
module testbench
  import event_latch_pkg::*;
;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic [DATA_W-1:0] reg_rdata;
  logic [NUM_CH-1:0] ext_event = '0, submit_done = '0, candidate, missed_event;
  logic tc_done_valid, tc_intermediate_chain_enable, tc_final_chain_enable, req = 1'b0;
  logic early_done_valid = 1'b0, early_intermediate_chain_enable = 1'b0;
  logic early_final_chain_enable = 1'b0;
  logic [CODE_W-1:0] tc_completion_code, early_completion_code = '0;
  logic [CODE_W+1:0] req_info = '0;
  logic [3:0] req_delay = '0;
  logic [ADDR_W-1:0] offs [7] = '{OFS_EVENT_PENDING_LOW, OFS_EVENT_PENDING_HIGH,
    OFS_EVENT_CLEAR_LOW, OFS_EVENT_CLEAR_HIGH, OFS_MANUAL_SET_LOW, OFS_MANUAL_SET_HIGH, 8'hFC};
  int errors = 0, tests_run = 0, cycles = 0;
  always #5 sys_clk = ~sys_clk;
  dma_channel_event_latch u_dut (.*);
  tc_model u_tc (.*);
  // ****************************************
  // Access tasks
  // ****************************************
  task automatic chk(string n, logic [NUM_CH-1:0] seen, logic [NUM_CH-1:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s exp %h seen %h", n, exp, seen);
    end
  endtask
  task automatic cyc(logic w, logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d,
                     logic [NUM_CH-1:0] ev, logic [NUM_CH-1:0] sd);
    @(posedge sys_clk);
    reg_write <= w;
    reg_addr <= a;
    reg_wdata <= d;
    ext_event <= ev;
    submit_done <= sd;
    @(posedge sys_clk);
    reg_write <= 1'b0;
    ext_event <= '0;
    submit_done <= '0;
    #1;
  endtask
  task automatic wr(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
    cyc(1'b1, a, d, '0, '0);
  endtask
  task automatic rd(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] exp);
    @(posedge sys_clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_read <= 1'b0;
    #1;
    chk("rdata", {32'h0, reg_rdata}, {32'h0, exp});
  endtask
  task automatic tc(logic [CODE_W+1:0] info, logic [3:0] dly);
    @(posedge sys_clk);
    req <= 1'b1;
    req_info <= info;
    req_delay <= dly;
    @(posedge sys_clk);
    req <= 1'b0;
    #1;
    for (int i = 0; i < 30 && tc_done_valid !== 1'b1; i++) begin
      @(posedge sys_clk);
      #1;
    end
    chk("tc done", {63'h0, tc_done_valid}, 64'h1);
    @(posedge sys_clk);
    #1;
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      final_report();
    end
  end
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    foreach (offs[i]) rd(offs[i], 32'h0);
    chk("cand", candidate, '0);
    $display("test reset done");
    cyc(1'b0, 8'h00, 32'h0, 64'h0000_0100_0000_0020, '0);
    rd(OFS_EVENT_PENDING_LOW, 32'h0000_0020);
    rd(OFS_EVENT_PENDING_HIGH, 32'h0000_0100);
    @(posedge sys_clk);
    #1 chk("rdata idle", {32'h0, reg_rdata}, '0);
    chk("cand", candidate, '0);
    cyc(1'b0, 8'h00, 32'h0, 64'h20, '0);
    chk("miss", missed_event, '0);
    wr(OFS_ENABLE_SET_LOW, 32'h20);
    chk("cand", candidate, 64'h20);
    cyc(1'b0, 8'h00, 32'h0, 64'h20, '0);
    chk("miss", missed_event, 64'h20);
    wr(OFS_EVENT_CLEAR_LOW, 32'h0);
    rd(OFS_EVENT_PENDING_LOW, 32'h20);
    wr(OFS_EVENT_CLEAR_HIGH, 32'h100);
    rd(OFS_EVENT_PENDING_HIGH, 32'h0);
    cyc(1'b0, 8'h00, 32'h0, '0, 64'h20);
    rd(OFS_EVENT_PENDING_LOW, 32'h0);
    chk("cand", candidate, '0);
    $display("test external done");
    wr(OFS_MANUAL_SET_LOW, 32'h4);
    chk("cand", candidate, 64'h4);
    rd(OFS_EVENT_PENDING_LOW, 32'h0);
    wr(OFS_EVENT_CLEAR_LOW, 32'h4);
    chk("cand", candidate, 64'h4);
    wr(OFS_MANUAL_SET_LOW, 32'h4);
    chk("miss", missed_event, 64'h24);
    wr(OFS_MANUAL_SET_LOW, 32'h0);
    rd(OFS_MANUAL_SET_LOW, 32'h4);
    cyc(1'b0, 8'h00, 32'h0, '0, 64'h4);
    chk("cand", candidate, '0);
    cyc(1'b1, OFS_MANUAL_SET_LOW, 32'h1, '0, 64'h1);
    chk("cand", candidate, 64'h1);
    cyc(1'b1, OFS_MANUAL_SET_LOW, 32'h1, '0, 64'h1);
    chk("cand", candidate, 64'h1);
    chk("miss", missed_event, 64'h25);
    wr(OFS_MANUAL_SET_HIGH, 32'h1);
    chk("cand", candidate, 64'h0000_0001_0000_0001);
    cyc(1'b0, 8'h00, 32'h0, '0, 64'h0000_0001_0000_0001);
    chk("cand", candidate, '0);
    $display("test manual done");
    tc({2'b01, 6'h03}, 4'h0);
    chk("cand", candidate, 64'h8);
    tc({2'b10, 6'h32}, 4'h4);
    rd(OFS_CHAIN_EVENT_HIGH, 32'h0004_0000);
    tc({2'b01, 6'h03}, 4'h2);
    chk("miss", missed_event, 64'h2D);
    tc({2'b00, 6'h09}, 4'h1);
    chk("cand", candidate, 64'h0004_0000_0000_0008);
    @(posedge sys_clk);
    early_done_valid <= 1'b1;
    early_completion_code <= 6'h07;
    early_final_chain_enable <= 1'b1;
    @(posedge sys_clk);
    early_done_valid <= 1'b0;
    early_completion_code <= 6'h38;
    early_final_chain_enable <= 1'b0;
    #1;
    chk("cand", candidate, 64'h0004_0000_0000_0088);
    cyc(1'b0, 8'h00, 32'h0, '0, 64'h0004_0000_0000_0088);
    chk("cand", candidate, '0);
    rd(OFS_CHAIN_EVENT_LOW, 32'h0);
    $display("test chain done");
    rd(OFS_MISSED_EVENT_LOW, 32'h2D);
    wr(OFS_MISSED_CLEAR_LOW, 32'h2D);
    chk("miss", missed_event, '0);
    rd(OFS_CHANNEL_ENABLE_LOW, 32'h20);
    cyc(1'b0, 8'h00, 32'h0, 64'h20, '0);
    chk("cand", candidate, 64'h20);
    wr(OFS_ENABLE_CLEAR_LOW, 32'h20);
    chk("cand", candidate, '0);
    rd(OFS_EVENT_PENDING_LOW, 32'h20);
    $display("test enable done");
    final_report();
  end
endmodule

bind dma_channel_event_latch event_latch_monitor u_mon (.*);
